// >>> dv/fcr_bank_props.sv
// Port checker for the coefficient bank.
`timescale 1ns/1ps
`default_nettype none
module fcr_bank_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fcr_pkg::fcr_bus_req_t bus_req,
  input wire fcr_pkg::fcr_word_t rd_data,
  input wire logic rd_valid,
  input wire fcr_pkg::fcr_chan_a_taps_t chan_a_taps,
  input wire fcr_pkg::fcr_chan_b_taps_t chan_b_taps,
  input wire fcr_pkg::fcr_mode_t chan_mode,
  input wire logic chan_b_active
);
  wire logic [11:0] a = bus_req.addr;
  wire logic [11:0] d = bus_req.wdata[11:0];
  wire logic [59:0] t = {chan_a_taps, chan_b_taps};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_a8; bus_req.wr && a == 12'h427 |=> ##1 t[59:48] == $past(d, 2); endproperty
  a_a8: assert property (p_a8) else $error("tap a8");
  property p_a9; bus_req.wr && a == 12'h429 |=> ##1 t[47:36] == $past(d, 2); endproperty
  a_a9: assert property (p_a9) else $error("tap a9");
  property p_b1; bus_req.wr && a == 12'h448 |=> ##1 t[35:24] == $past(d, 2); endproperty
  a_b1: assert property (p_b1) else $error("tap b1");
  property p_b2; bus_req.wr && a == 12'h44A |=> ##1 t[23:12] == $past(d, 2); endproperty
  a_b2: assert property (p_b2) else $error("tap b2");
  property p_b3; bus_req.wr && a == 12'h44C |=> ##1 t[11:0] == $past(d, 2); endproperty
  a_b3: assert property (p_b3) else $error("tap b3");
  property p_rd; bus_req.rd |=> rd_valid && !rd_data[11]; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_vld; rd_valid |-> $past(bus_req.rd); endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_rst; disable iff (1'b0) !rst_n ##1 !rst_n |=> t == 60'h0 && !rd_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_act; $past(rst_n) |-> chan_b_active == $past(chan_mode == fcr_pkg::FCR_MODE_DUAL); endproperty
  a_act: assert property (p_act) else $error("channel b active");
endmodule : fcr_bank_props
bind fcr_bank fcr_bank_props fcr_bank_props_inst (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .chan_a_taps(chan_a_taps),
  .chan_b_taps(chan_b_taps),
  .chan_mode(chan_mode),
  .chan_b_active(chan_b_active)
);
`default_nettype wire

// >>> dv/fcr_bank_tb_top.sv
// Bench for the coefficient bank.
`timescale 1ns/1ps
`default_nettype none
module fcr_bank_tb_top;
  import fcr_pkg::*;
  logic ref_clk = 0;
  logic rst_n = 0;
  fcr_bus_req_t bus_req = '0;
  fcr_mode_t chan_mode = FCR_MODE_DUAL;
  fcr_word_t rd_data;
  logic rd_valid, chan_b_active;
  fcr_chan_a_taps_t chan_a_taps;
  fcr_chan_b_taps_t chan_b_taps;
  int n_errors = 0;
  int n_tests = 0;
  logic [11:0] ofs [5] = '{12'h427, 12'h429, 12'h448, 12'h44A, 12'h44C};
  fcr_word_t v [5] = '{16'hF801, 16'h37FF, 16'hA802, 16'h5C03, 16'h0FFE};
  fcr_bank fcr_bank_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .chan_mode(chan_mode),
    .chan_a_taps(chan_a_taps),
    .chan_b_taps(chan_b_taps),
    .chan_b_active(chan_b_active)
  );
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(string s, logic [59:0] e, logic [59:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic acc(logic w, logic [11:0] a, fcr_word_t d);
    bus_req <= '{w, !w, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    if (!w) chk("read", 60'({1'b1, d & 16'hF7FF}), 60'({rd_valid, rd_data}));
  endtask : acc
  task automatic t_regs;
    for (int i = 0; i < 5; i++) acc(0, ofs[i], 16'h0000);
    chk("taps", 60'h0, {chan_a_taps, chan_b_taps});
    for (int i = 0; i < 5; i++) acc(1, ofs[i], v[i]);
    @(posedge ref_clk);
    #1;
    chk("taps", 60'h8017FF802C03FFE, {chan_a_taps, chan_b_taps});
    for (int i = 0; i < 5; i++) acc(0, ofs[i], v[i]);
    acc(0, 12'h428, 16'h0000);
    $display("register test done");
  endtask : t_regs
  task automatic t_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("taps", 60'h0, {chan_a_taps, chan_b_taps});
    for (int i = 0; i < 5; i++) acc(0, ofs[i], 16'h0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_mode;
    chan_mode <= FCR_MODE_SINGLE;
    acc(1, 12'h448, 16'h0123);
    @(posedge ref_clk);
    #1;
    chk("active", 60'h0, 60'(chan_b_active));
    chk("tap one", 60'h123, 60'(chan_b_taps.tap_one));
    chan_mode <= FCR_MODE_DUAL;
    @(posedge ref_clk);
    #1;
    chk("active", 60'h1, 60'(chan_b_active));
    $display("mode test done");
  endtask : t_mode
  task automatic conclude;
    $display("%0d checks, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_regs();
    t_reset();
    t_mode();
    conclude();
  end
endmodule : fcr_bank_tb_top
`default_nettype wire

// >>> logic/fcr_bank.sv
// Coefficient register bank for the programmable equalizer filter, taps eight and nine of A, one to three of B.
// What this block does
// - Each register holds a signed twelve-bit coefficient in bits 11:0.
// - After reset every register, reserved bits included, reads zero.
// - Readback returns the coefficient's top bit as zero whatever was written.
// - Offset 0x427 feeds channel A tap eight, or sole filter tap eight.
// - Offset 0x429 feeds channel A tap nine, or sole filter tap nine.
// - Offset 0x448 feeds channel B tap one, used only in dual mode.
// - Offset 0x44A feeds channel B tap two in dual mode.
// - Offset 0x44C feeds channel B tap three in dual mode.
// - The filter has nine taps; the centre tap is eighteen bits, others twelve.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_regs.svh"

module fcr_bank (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fcr_pkg::fcr_bus_req_t bus_req,
  output fcr_pkg::fcr_word_t rd_data,
  output logic rd_valid,
  input wire fcr_pkg::fcr_mode_t chan_mode,
  output fcr_pkg::fcr_chan_a_taps_t chan_a_taps,
  output fcr_pkg::fcr_chan_b_taps_t chan_b_taps,
  output logic chan_b_active
);
  import fcr_pkg::*;

  // Cell order: A tap eight, A tap nine, B tap one, B tap two, B tap three.
  localparam fcr_addr_t REG_OFS [`FCR_NUM_REGS] = '{
    `FCR_CHAN_A_TAP_EIGHT_COEF_OFS,
    `FCR_CHAN_A_TAP_NINE_COEF_OFS,
    `FCR_CHAN_B_TAP_ONE_COEF_OFS,
    `FCR_CHAN_B_TAP_TWO_COEF_OFS,
    `FCR_CHAN_B_TAP_THREE_COEF_OFS
  };

  localparam logic [`FCR_TAP_IDX_W-1:0] REG_TAP [`FCR_NUM_REGS] = '{
    `FCR_CHAN_A_TAP_EIGHT_IDX,
    `FCR_CHAN_A_TAP_NINE_IDX,
    `FCR_CHAN_B_TAP_ONE_IDX,
    `FCR_CHAN_B_TAP_TWO_IDX,
    `FCR_CHAN_B_TAP_THREE_IDX
  };

  logic [`FCR_NUM_REGS-1:0] addr_hit;
  logic [`FCR_NUM_REGS-1:0] wr_sel;
  fcr_word_t cell_stored [`FCR_NUM_REGS];
  fcr_word_t cell_readback [`FCR_NUM_REGS];
  fcr_coef_t cell_coef [`FCR_NUM_REGS];
  fcr_word_t rd_mux;
  fcr_word_t rd_data_reg;
  fcr_word_t rd_data_next;
  logic rd_valid_reg;
  logic chan_b_active_reg;
  fcr_chan_a_taps_t chan_a_taps_reg;
  fcr_chan_b_taps_t chan_b_taps_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `FCR_NUM_REGS; gi = gi + 1) begin : g_cell
      assign addr_hit[gi] = (bus_req.addr == REG_OFS[gi]);
      assign wr_sel[gi] = bus_req.wr & addr_hit[gi];

      fcr_coef_cell u_cell (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(wr_sel[gi]),
        .wdata(bus_req.wdata),
        .stored(cell_stored[gi]),
        .readback(cell_readback[gi]),
        .coef(cell_coef[gi])
      );
    end
  endgenerate

  // Unmapped addresses read as zero; the hit vector has at most one bit set by construction.
  always_comb begin
    rd_mux = `FCR_REG_RESET;
    for (int i = 0; i < `FCR_NUM_REGS; i++) begin
      if (addr_hit[i]) begin
        rd_mux = cell_readback[i];
      end
    end
  end

  assign rd_data_next = bus_req.rd ? rd_mux : `FCR_REG_RESET;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_reg <= `FCR_REG_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= bus_req.rd;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chan_a_taps_reg <= '0;
    end else begin
      chan_a_taps_reg <= '{tap_eight: cell_coef[0], tap_nine: cell_coef[1]};
    end
  end

  // channel B taps, meaningful only in dual mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chan_b_taps_reg <= '0;
      chan_b_active_reg <= 1'b0;
    end else begin
      chan_b_taps_reg <= '{tap_one: cell_coef[2], tap_two: cell_coef[3], tap_three: cell_coef[4]};
      chan_b_active_reg <= (chan_mode == FCR_MODE_DUAL);
    end
  end

  assign chan_a_taps = chan_a_taps_reg;
  assign chan_b_taps = chan_b_taps_reg;
  assign chan_b_active = chan_b_active_reg;

endmodule : fcr_bank

`default_nettype wire

// >>> logic/fcr_coef_cell.sv
// One sixteen-bit coefficient register with its masked readback view.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_regs.svh"

module fcr_coef_cell (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire fcr_pkg::fcr_word_t wdata,
  output fcr_pkg::fcr_word_t stored,
  output fcr_pkg::fcr_word_t readback,
  output fcr_pkg::fcr_coef_t coef
);
  import fcr_pkg::*;

  fcr_word_t word_reg;
  fcr_word_t word_next;

  assign word_next = wr_en ? wdata : word_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      word_reg <= `FCR_REG_RESET;
    end else begin
      word_reg <= word_next;
    end
  end

  assign stored = word_reg;

  assign coef = word_reg[`FCR_COEF_MSB:`FCR_COEF_LSB];

  assign readback = {word_reg[`FCR_RSVD_MSB:`FCR_RSVD_LSB], 1'b0, word_reg[`FCR_COEF_MSB-1:`FCR_COEF_LSB]};

endmodule : fcr_coef_cell

`default_nettype wire

// >>> logic/fcr_pkg.sv
// Types shared by the equalizer coefficient bank and its register cells.
`include "fcr_regs.svh"

package fcr_pkg;

  typedef logic signed [`FCR_COEF_W-1:0] fcr_coef_t;
  typedef logic signed [`FCR_CENTER_COEF_W-1:0] fcr_center_coef_t;
  typedef logic [`FCR_DATA_W-1:0] fcr_word_t;
  typedef logic [`FCR_ADDR_W-1:0] fcr_addr_t;

  typedef enum logic {
    FCR_MODE_SINGLE,
    FCR_MODE_DUAL
  } fcr_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    fcr_addr_t addr;
    fcr_word_t wdata;
  } fcr_bus_req_t;

  typedef struct packed {
    fcr_coef_t tap_eight;
    fcr_coef_t tap_nine;
  } fcr_chan_a_taps_t;

  typedef struct packed {
    fcr_coef_t tap_one;
    fcr_coef_t tap_two;
    fcr_coef_t tap_three;
  } fcr_chan_b_taps_t;

endpackage : fcr_pkg

// >>> logic/fcr_regs.svh
// Offsets, field positions, reset values and tap figures of the equalizer coefficient bank.
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

`define FCR_ADDR_W 12
`define FCR_DATA_W 16
`define FCR_NUM_REGS 5
`define FCR_IDX_W 3

`define FCR_CHAN_A_TAP_EIGHT_COEF_OFS 12'h427
`define FCR_CHAN_A_TAP_NINE_COEF_OFS 12'h429
`define FCR_CHAN_B_TAP_ONE_COEF_OFS 12'h448
`define FCR_CHAN_B_TAP_TWO_COEF_OFS 12'h44A
`define FCR_CHAN_B_TAP_THREE_COEF_OFS 12'h44C

`define FCR_REG_RESET 16'h0000
`define FCR_COEF_MSB 11
`define FCR_COEF_LSB 0
`define FCR_RSVD_MSB 15
`define FCR_RSVD_LSB 12
`define FCR_COEF_W 12
`define FCR_CENTER_COEF_W 18

`define FCR_NUM_TAPS 9
`define FCR_TAP_IDX_W 4
`define FCR_CENTER_TAP_IDX 4'h4
`define FCR_CHAN_A_TAP_EIGHT_IDX 4'h7
`define FCR_CHAN_A_TAP_NINE_IDX 4'h8
`define FCR_CHAN_B_TAP_ONE_IDX 4'h0
`define FCR_CHAN_B_TAP_TWO_IDX 4'h1
`define FCR_CHAN_B_TAP_THREE_IDX 4'h2

`endif
